// file: core/cex_exec_unit.sv
// integer execute stage, register file and multiply/divide unit
// assumes the issuing pipeline holds an mdu op while stall_o is high
`timescale 1ns/1ns
`include "cex_cfg.svh"
module cex_exec_unit #(
  parameter int RF_SETS = `CEX_RF_SETS
) (
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  input  wire logic                   pipe_hold_i,
  input  wire cex_pkg::cex_issue_type issue_i,
  output cex_pkg::cex_result_type     result_o,
  output logic                        stall_o,
  output logic [31:0]                 upper_result_o,
  output logic [31:0]                 bottom_result_o
);

  if (RF_SETS < 1 || RF_SETS > 2) begin : g_chk
    $error("cex_exec_unit: one or two register sets only");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cex_pkg::cex_result_type    wb_q;
  logic [31:0]                rf_q [RF_SETS*`CEX_GPR_COUNT];
  logic [31:0]                upper_result_reg_q;
  logic [31:0]                bottom_result_reg_q;
  cex_pkg::cex_mdu_state_type st_q;
  logic                       stall_q;
  logic [5:0]                 cnt_q;
  logic [31:0]                mul_a_q;
  logic [15:0]                mul_bh_q;
  logic [32:0]                rem_q;
  logic [31:0]                dq_q;
  logic [31:0]                dvs_q;
  logic                       neg_quo_q;
  logic                       neg_rem_q;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] rf_idx(input logic s, input logic [4:0] a);
    return {s & (RF_SETS > 1), a};
  endfunction : rf_idx

  function automatic logic [31:0] read_gpr(input logic s,
                                           input logic [4:0] a);
    if (a == 5'h00)
      return 32'h0000_0000;
    if (wb_q.valid && wb_q.set == s && wb_q.dst == a)
      return wb_q.data;
    return rf_q[rf_idx(s, a)];
  endfunction : read_gpr

  function automatic logic signed [48:0] booth_mul(
      input logic signed [31:0] a, input logic [16:0] b);
    logic        [18:0] bx;
    logic        [2:0]  grp;
    logic signed [48:0] acc;
    logic signed [48:0] pp;
    bx  = {b[16], b, 1'b0};
    acc = '0;
    for (int i = 0; i < 9; i++) begin
      grp = bx[2*i +: 3];
      case (grp)
        3'h1, 3'h2: pp = 49'(a);
        3'h3:       pp = 49'(a) <<< 1;
        3'h4:       pp = -(49'(a) <<< 1);
        3'h5, 3'h6: pp = -49'(a);
        default:    pp = '0;
      endcase
      acc = acc + (pp <<< (2 * i));
    end
    return acc;
  endfunction : booth_mul

  function automatic logic fits_slice(input logic [31:0] b);
    return b[31:15] == {17{b[15]}};
  endfunction : fits_slice

  function automatic logic [5:0] div_skip(input logic [31:0] a);
    if (a[31:7] == {25{a[7]}})
      return `CEX_SKIP_W8;
    if (a[31:15] == {17{a[15]}})
      return `CEX_SKIP_W16;
    if (a[31:23] == {9{a[23]}})
      return `CEX_SKIP_W24;
    return `CEX_SKIP_NONE;
  endfunction : div_skip

  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? -v : v;
  endfunction : mag

  // ----------------------------------------------------------------
  // operand read and issue decode
  // ----------------------------------------------------------------
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic        is_mdu;
  logic        take;
  logic        writes;
  logic [5:0]  lz_cnt;
  logic [31:0] alu_res;
  logic [5:0]  skip;

  always_comb begin
    op_a = read_gpr(issue_i.set, issue_i.src_a);
    op_b = issue_i.use_imm ? {{16{issue_i.imm[15]}}, issue_i.imm}
                           : read_gpr(issue_i.set, issue_i.src_b);
  end

  always_comb begin
    is_mdu = issue_i.op inside {cex_pkg::OP_MUL, cex_pkg::OP_DIV,
                                cex_pkg::OP_MFHI, cex_pkg::OP_MFLO};
    take   = issue_i.valid && !pipe_hold_i && !(is_mdu && stall_q);
    writes = !(issue_i.op inside {cex_pkg::OP_MUL, cex_pkg::OP_DIV});
    skip   = div_skip(op_a);
  end

  cex_lzd #(
    .WIDTH (`CEX_XLEN),
    .CW    (6)
  ) u_lzd (
    .value_i (op_a),
    .ones_i  (issue_i.op == cex_pkg::OP_CLO),
    .count_o (lz_cnt)
  );

  // single cycle alu, no memory path
  always_comb begin
    unique case (issue_i.op)
      cex_pkg::OP_ADD:  alu_res = op_a + op_b;
      cex_pkg::OP_SUB:  alu_res = op_a - op_b;
      cex_pkg::OP_AND:  alu_res = op_a & op_b;
      cex_pkg::OP_OR:   alu_res = op_a | op_b;
      cex_pkg::OP_XOR:  alu_res = op_a ^ op_b;
      cex_pkg::OP_NOR:  alu_res = ~(op_a | op_b);
      cex_pkg::OP_SLL:  alu_res = op_a << op_b[4:0];
      cex_pkg::OP_SRL:  alu_res = op_a >> op_b[4:0];
      cex_pkg::OP_SRA:  alu_res = 32'($signed(op_a) >>> op_b[4:0]);
      cex_pkg::OP_CLZ,
      cex_pkg::OP_CLO:  alu_res = {26'h0, lz_cnt};
      cex_pkg::OP_MFHI: alu_res = upper_result_reg_q;
      cex_pkg::OP_MFLO: alu_res = bottom_result_reg_q;
      default:          alu_res = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // writeback and register file
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wb_q <= '0;
    end else begin
      wb_q.valid <= take && writes;
      wb_q.set   <= issue_i.set;
      wb_q.dst   <= issue_i.dst;
      wb_q.data  <= alu_res;
    end
  end

  // one write per cycle, set chosen per op
  always_ff @(posedge clock_i) begin
    if (wb_q.valid && wb_q.dst != 5'h00) begin
      rf_q[rf_idx(wb_q.set, wb_q.dst)] <= wb_q.data;
    end
  end

  // ----------------------------------------------------------------
  // multiply/divide unit
  // ----------------------------------------------------------------
  logic [63:0] prod_one;
  logic [63:0] prod_lo;
  logic [63:0] prod_hi;
  logic [32:0] rem_sh;
  logic        ge;
  logic [32:0] rem_nx;
  logic [31:0] quo_nx;

  // passes chosen by operand b only
  always_comb begin
    prod_one = 64'(booth_mul(op_a, {op_b[15], op_b[15:0]}));
    prod_lo  = 64'(booth_mul(op_a, {1'b0, op_b[15:0]}));
    prod_hi  = 64'(booth_mul(mul_a_q, {mul_bh_q[15], mul_bh_q})) <<< 16;
  end

  always_comb begin
    rem_sh = {rem_q[31:0], dq_q[31]};
    ge     = rem_sh >= {1'b0, dvs_q};
    rem_nx = ge ? rem_sh - {1'b0, dvs_q} : rem_sh;
    quo_nx = {dq_q[30:0], ge};
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q                <= cex_pkg::MDU_IDLE;
      stall_q             <= 1'b0;
      cnt_q               <= 6'h00;
      upper_result_reg_q  <= `CEX_RESULT_RST;
      bottom_result_reg_q <= `CEX_RESULT_RST;
      mul_a_q             <= 32'h0000_0000;
      mul_bh_q            <= 16'h0000;
      rem_q               <= 33'h0_0000_0000;
      dq_q                <= 32'h0000_0000;
      dvs_q               <= 32'h0000_0000;
      neg_quo_q           <= 1'b0;
      neg_rem_q           <= 1'b0;
    end else begin
      unique case (st_q)
        cex_pkg::MDU_IDLE: begin
          if (take && issue_i.op == cex_pkg::OP_MUL) begin
            if (fits_slice(op_b)) begin
              {upper_result_reg_q, bottom_result_reg_q} <= prod_one;
            end else begin
              {upper_result_reg_q, bottom_result_reg_q} <= prod_lo;
              mul_a_q  <= op_a;
              mul_bh_q <= op_b[31:16];
              st_q     <= cex_pkg::MDU_MUL2;
              stall_q  <= 1'b1;
            end
          end else if (take && issue_i.op == cex_pkg::OP_DIV) begin
            cnt_q     <= `CEX_DIV_FULL_ITER - skip;
            dq_q      <= mag(op_a) << skip;
            dvs_q     <= mag(op_b);
            rem_q     <= 33'h0_0000_0000;
            neg_quo_q <= op_a[31] ^ op_b[31];
            neg_rem_q <= op_a[31];
            st_q      <= cex_pkg::MDU_DIV;
            stall_q   <= 1'b1;
          end
        end
        cex_pkg::MDU_MUL2: begin
          {upper_result_reg_q, bottom_result_reg_q} <=
            {upper_result_reg_q, bottom_result_reg_q} + prod_hi;
          st_q    <= cex_pkg::MDU_IDLE;
          stall_q <= 1'b0;
        end
        cex_pkg::MDU_DIV: begin
          rem_q <= rem_nx;
          dq_q  <= quo_nx;
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            bottom_result_reg_q <= neg_quo_q ? -quo_nx : quo_nx;
            upper_result_reg_q  <= neg_rem_q ? -rem_nx[31:0] : rem_nx[31:0];
            st_q                <= cex_pkg::MDU_IDLE;
            stall_q             <= 1'b0;
          end
        end
        default: begin
          st_q    <= cex_pkg::MDU_IDLE;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result_o        = wb_q;
  assign stall_o         = stall_q;
  assign upper_result_o  = upper_result_reg_q;
  assign bottom_result_o = bottom_result_reg_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  logic [31:0] sum_chk;
  logic [63:0] mul_chk;
  logic [31:0] dvd_chk_q;
  logic [31:0] dvs_chk_q;

  assign sum_chk = op_a + op_b;
  assign mul_chk = 64'({{32{op_a[31]}}, op_a} * {{32{op_b[31]}}, op_b});

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      dvd_chk_q <= 32'h0000_0000;
      dvs_chk_q <= 32'h0000_0000;
    end else if (take && issue_i.op == cex_pkg::OP_DIV && !stall_q) begin
      dvd_chk_q <= op_a;
      dvs_chk_q <= op_b;
    end
  end

  sequence s_wide_mul;
    take && issue_i.op == cex_pkg::OP_MUL && !stall_q && !fits_slice(op_b);
  endsequence

  sequence s_one_busy;
    stall_o ##1 !stall_o;
  endsequence

  sequence s_div8;
    take && issue_i.op == cex_pkg::OP_DIV && !stall_q &&
      op_a[31:7] == {25{op_a[7]}};
  endsequence

  a_alu_add_one: assert property (
    take && issue_i.op == cex_pkg::OP_ADD |=>
      result_o.valid && result_o.data == $past(sum_chk))
    else $error("add result not ready one cycle later");

  a_bypass_fwd: assert property (
    result_o.valid && result_o.dst != 5'h00 &&
      result_o.set == issue_i.set && result_o.dst == issue_i.src_a |->
      op_a == result_o.data)
    else $error("operand a not forwarded from writeback");

  a_clz_zero: assert property (
    take && issue_i.op == cex_pkg::OP_CLZ && op_a == 32'h0000_0000 |=>
      result_o.data == 32'h0000_0020)
    else $error("leading zero count of zero is not 32");

  a_wide_mul_busy: assert property (
    s_wide_mul |=> s_one_busy)
    else $error("wide multiply not busy exactly one cycle");

  a_narrow_mul_prod: assert property (
    take && issue_i.op == cex_pkg::OP_MUL && !stall_q && fits_slice(op_b)
      |=> !stall_o &&
      {upper_result_o, bottom_result_o} == $past(mul_chk))
    else $error("narrow multiply wrong or stalled");

  a_wide_mul_prod: assert property (
    s_wide_mul |-> ##2
      {upper_result_o, bottom_result_o} == $past(mul_chk, 2))
    else $error("wide multiply product wrong after two passes");

  a_div_skip_8: assert property (
    s_div8 |=> cnt_q == 6'h09 ##9 !stall_o)
    else $error("byte dividend not finished after nine steps");

  a_div_hold_hilo: assert property (
    st_q == cex_pkg::MDU_DIV && cnt_q > 6'h01 |=>
      $stable(upper_result_o) && $stable(bottom_result_o))
    else $error("result registers changed during divide");

  a_div_result: assert property (
    st_q == cex_pkg::MDU_DIV && cnt_q == 6'h01 &&
      dvs_chk_q != 32'h0000_0000 |=>
      32'(bottom_result_o * dvs_chk_q) + upper_result_o == dvd_chk_q)
    else $error("quotient times divisor plus remainder mismatch");

  a_div_hold_adv: assert property (
    pipe_hold_i && st_q == cex_pkg::MDU_DIV && cnt_q > 6'h01 |=>
      cnt_q == $past(cnt_q) - 6'h01)
    else $error("divide stopped during pipeline hold");

endmodule : cex_exec_unit

// file: core/cex_lzd.sv
// leading zero / leading one counter
// assumes a combinational use inside the execute stage
`timescale 1ns/1ns
`include "cex_cfg.svh"
module cex_lzd #(
  parameter int WIDTH = `CEX_XLEN,
  parameter int CW    = 6
) (
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic             ones_i,
  output logic      [CW-1:0]    count_o
);

  if (2 ** CW <= WIDTH) begin : g_chk
    $error("cex_lzd: count width too small");
  end

  always_comb begin : p_count
    logic [WIDTH-1:0] v;
    logic             hit;
    v       = ones_i ? ~value_i : value_i;
    hit     = 1'b0;
    count_o = CW'(WIDTH);
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (!hit && v[i]) begin
        count_o = CW'(WIDTH - 1 - i);
        hit     = 1'b1;
      end
    end
  end

endmodule : cex_lzd

// file: include/cex_cfg.svh
// constants of the integer execution unit and its multiply/divide unit
// assumes one pipeline clock and a synchronous active-low reset
//
// Overview of operation
// - alu ops finish in one cycle, no memory
// - thirty-two 32-bit general purpose registers
// - full shadow register set for exceptions
// - two read ports, one write port
// - bypass results to following dependent instructions
// - leading zero and leading one counter
// - multiply/divide pipeline runs during pipeline stalls
// - 32x16 booth multiplier plus divide machine
// - results held in upper and bottom registers
// - pass count set by operand b only
// - 16-bit b one pass, 32-bit two
// - 16-bit multiply accepted every cycle
// - wide multiplies interlocked to every other cycle
// - operand size detected by unit itself
// - divide resolves one quotient bit per clock
// - dividend sign extension gives effective width
// - 8-bit dividend skips 23 iterations
// - 16-bit dividend skips 15 iterations
// - 24-bit dividend skips 7 iterations
// - new mdu op stalls until divide completes
`ifndef CEX_CFG_SVH
`define CEX_CFG_SVH

`define CEX_XLEN          32
`define CEX_GPR_COUNT     32
`define CEX_RF_SETS       2
`define CEX_MUL_SLICE     16
`define CEX_DIV_FULL_ITER 6'h20
`define CEX_SKIP_W8       6'h17
`define CEX_SKIP_W16      6'h0F
`define CEX_SKIP_W24      6'h07
`define CEX_SKIP_NONE     6'h00
`define CEX_RESULT_RST    32'h0000_0000

`endif

// file: include/cex_pkg.sv
// types of the integer execution unit
// assumes cex_cfg.svh is compiled alongside
package cex_pkg;

  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_AND  = 4'h2,
    OP_OR   = 4'h3,
    OP_XOR  = 4'h4,
    OP_NOR  = 4'h5,
    OP_SLL  = 4'h6,
    OP_SRL  = 4'h7,
    OP_SRA  = 4'h8,
    OP_CLZ  = 4'h9,
    OP_CLO  = 4'hA,
    OP_MUL  = 4'hB,
    OP_DIV  = 4'hC,
    OP_MFHI = 4'hD,
    OP_MFLO = 4'hE
  } cex_op_type;

  typedef enum logic [2:0] {
    MDU_IDLE = 3'h1,
    MDU_MUL2 = 3'h2,
    MDU_DIV  = 3'h4
  } cex_mdu_state_type;

  typedef struct packed {
    logic        valid;
    cex_op_type  op;
    logic        set;
    logic [4:0]  dst;
    logic [4:0]  src_a;
    logic [4:0]  src_b;
    logic        use_imm;
    logic [15:0] imm;
  } cex_issue_type;

  typedef struct packed {
    logic        valid;
    logic        set;
    logic [4:0]  dst;
    logic [31:0] data;
  } cex_result_type;

endpackage : cex_pkg

// file: tb/cex_exec_unit_tb.sv
// self-checking bench of the execution unit and multiply/divide unit
// assumes cex_issuer_model plays the issuing pipeline
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module cex_exec_unit_tb;
  logic                    clock_i;
  logic                    nrst_i;
  logic                    pipe_hold_i;
  logic                    stall_o;
  cex_pkg::cex_issue_type  issue_i;
  cex_pkg::cex_result_type result_o;
  logic [31:0]             upper_result_o;
  logic [31:0]             bottom_result_o;
  int                      bad_count;
  int                      n_tests;
  int                      cyc;

  cex_exec_unit uut (
    .clock_i         (clock_i),
    .nrst_i          (nrst_i),
    .pipe_hold_i     (pipe_hold_i),
    .issue_i         (issue_i),
    .result_o        (result_o),
    .stall_o         (stall_o),
    .upper_result_o  (upper_result_o),
    .bottom_result_o (bottom_result_o)
  );
  cex_issuer_model pipe (
    .clock_i (clock_i),
    .hold_i  (pipe_hold_i),
    .stall_i (stall_o),
    .issue_o (issue_i)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic cex_pkg::cex_issue_type mk(cex_pkg::cex_op_type o,
      logic s, logic [4:0] d, logic [4:0] a, logic [4:0] b, logic ui,
      logic [15:0] im);
    return '{1'b1, o, s, d, a, b, ui, im};
  endfunction : mk

  function automatic logic [31:0] lead(logic [31:0] v, logic one);
    int n = 0;
    while (n < 32 && v[31-n] == one) n++;
    return n;
  endfunction : lead

  function automatic logic [63:0] prod(logic [31:0] a, logic [31:0] b);
    logic signed [63:0] x = $signed(a);
    logic signed [63:0] y = $signed(b);
    return x * y;
  endfunction : prod

  task automatic alu(cex_pkg::cex_op_type o, logic s, logic [4:0] d,
      logic [4:0] a, logic [4:0] b, logic ui, logic [15:0] im,
      logic [31:0] e);
    int w;
    pipe.send(mk(o, s, d, a, b, ui, im), w);
    `CHK(w, 0)
    `CHK(result_o.valid, 1'b1)
    `CHK(result_o.dst, d)
    `CHK(result_o.data, e)
  endtask : alu

  task automatic ld(logic s, logic [4:0] r, logic [31:0] v);
    logic [15:0] hi;
    hi = v[31:16] + {15'h0000, v[15]};
    alu(cex_pkg::OP_ADD, s, r, 5'h00, 5'h00, 1'b1, hi, 32'(signed'(hi)));
    alu(cex_pkg::OP_SLL, s, r, r, 5'h00, 1'b1, 16'h0010, {hi, 16'h0000});
    alu(cex_pkg::OP_ADD, s, r, r, 5'h00, 1'b1, v[15:0], v);
  endtask : ld

  task automatic mul(logic [4:0] a, logic [4:0] b, output int w);
    pipe.send(mk(cex_pkg::OP_MUL, 1'b0, 5'h00, a, b, 1'b0, 16'h0000), w);
  endtask : mul

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alu;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    cex_pkg::cex_op_type o;
    a = 32'h8421_F00F;
    b = 32'h0000_0013;
    ld(1'b0, 5'h01, a);
    ld(1'b0, 5'h02, b);
    for (int i = 0; i < 9; i++) begin
      o = cex_pkg::cex_op_type'(i);
      case (o)
        cex_pkg::OP_ADD: e = a + b;
        cex_pkg::OP_SUB: e = a - b;
        cex_pkg::OP_AND: e = a & b;
        cex_pkg::OP_OR:  e = a | b;
        cex_pkg::OP_XOR: e = a ^ b;
        cex_pkg::OP_NOR: e = ~(a | b);
        cex_pkg::OP_SLL: e = a << b[4:0];
        cex_pkg::OP_SRL: e = a >> b[4:0];
        default:         e = $signed(a) >>> b[4:0];
      endcase
      alu(o, 1'b0, 5'h03, 5'h01, 5'h02, 1'b0, 16'h0000, e);
    end
    ld(1'b1, 5'h01, 32'h1234_5678);
    ld(1'b0, 5'h1F, 32'hCAFE_0001);
    alu(cex_pkg::OP_OR, 1'b1, 5'h04, 5'h01, 5'h00, 1'b0, 16'h0000,
        32'h1234_5678);
    alu(cex_pkg::OP_OR, 1'b0, 5'h04, 5'h01, 5'h1F, 1'b0, 16'h0000,
        a | 32'hCAFE_0001);
  endtask : t_alu

  task automatic t_lead;
    logic [31:0] v [4];
    v = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h0001_8000, 32'hF0FF_0000};
    foreach (v[i]) begin
      ld(1'b0, 5'h06, v[i]);
      alu(cex_pkg::OP_CLZ, 1'b0, 5'h07, 5'h06, 5'h00, 1'b0, 16'h0000,
          lead(v[i], 1'b0));
      alu(cex_pkg::OP_CLO, 1'b0, 5'h07, 5'h06, 5'h00, 1'b0, 16'h0000,
          lead(v[i], 1'b1));
    end
  endtask : t_lead

  task automatic t_mul;
    int w;
    ld(1'b0, 5'h08, 32'h8000_1235);
    ld(1'b0, 5'h09, 32'hFFFF_FFFD);
    ld(1'b0, 5'h0A, 32'h0000_7FFF);
    ld(1'b0, 5'h0B, 32'h0003_0001);
    mul(5'h08, 5'h09, w);
    `CHK({w, stall_o}, {32'h0, 1'b0})
    `CHK({upper_result_o, bottom_result_o}, prod(32'h8000_1235, -3))
    mul(5'h08, 5'h0A, w);
    `CHK({w, stall_o}, {32'h0, 1'b0})
    `CHK({upper_result_o, bottom_result_o},
         prod(32'h8000_1235, 32'h7FFF))
    mul(5'h08, 5'h0B, w);
    `CHK(stall_o, 1'b1)
    pipe.idle();
    @(posedge clock_i);
    #1;
    `CHK(stall_o, 1'b0)
    `CHK({upper_result_o, bottom_result_o},
         prod(32'h8000_1235, 32'h0003_0001))
    mul(5'h0A, 5'h0B, w);
    mul(5'h08, 5'h0B, w);
    `CHK(w, 1)
    pipe.idle();
    @(posedge clock_i);
    #1;
    `CHK({upper_result_o, bottom_result_o},
         prod(32'h8000_1235, 32'h0003_0001))
  endtask : t_mul

  task automatic t_div;
    logic [31:0] v [4];
    int          n [4];
    int          w;
    logic [31:0] q;
    logic [31:0] r;
    v = '{32'h0000_0064, 32'hFFFF_FC18, 32'h0010_0000, 32'h4000_0000};
    n = '{9, 17, 25, 32};
    ld(1'b0, 5'h0C, 32'h0000_0007);
    foreach (v[i]) begin
      q = $signed(v[i]) / 7;
      r = $signed(v[i]) % 7;
      ld(1'b0, 5'h0D, v[i]);
      pipe.send(mk(cex_pkg::OP_DIV, 1'b0, 5'h00, 5'h0D, 5'h0C, 1'b0,
                   16'h0000), w);
      if (i == 0) begin
        pipe.idle();
        pipe_hold_i = 1'b1;
        w = 0;
        while (stall_o === 1'b1 && w < 40) begin
          @(posedge clock_i);
          #1;
          w++;
        end
        `CHK(w, n[i])
        @(negedge clock_i);
        pipe_hold_i = 1'b0;
        `CHK({upper_result_o, bottom_result_o}, {r, q})
      end else begin
        pipe.send(mk(cex_pkg::OP_MFLO, 1'b0, 5'h0E, 5'h00, 5'h00, 1'b0,
                     16'h0000), w);
        `CHK(w, n[i])
        `CHK(result_o.data, q)
        alu(cex_pkg::OP_MFHI, 1'b0, 5'h0F, 5'h00, 5'h00, 1'b0, 16'h0000,
            r);
      end
    end
  endtask : t_div

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    nrst_i = 1'b0;
    pipe_hold_i = 1'b0;
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    `CHK({result_o, stall_o, upper_result_o, bottom_result_o},
         {$bits(result_o)+65{1'b0}})
    nrst_i = 1'b1;
    t_alu();
    t_lead();
    t_mul();
    t_div();
    pipe.idle();
    end_of_test();
  end
endmodule : cex_exec_unit_tb

// file: tb/cex_issuer_model.sv
// stand-in for the integer pipeline that offers instructions to the unit
// assumes stall_i is the unit's registered busy flag, hold_i the pipe stall
`timescale 1ns/1ns
module cex_issuer_model (
  input  wire logic              clock_i,
  input  wire logic              hold_i,
  input  wire logic              stall_i,
  output cex_pkg::cex_issue_type issue_o
);
  // ----------------------------------------------------------------
  // issue side
  // ----------------------------------------------------------------
  initial begin
    issue_o = '0;
  end

  task automatic send(input cex_pkg::cex_issue_type op, output int waits);
    logic multiply_divide_unit;
    multiply_divide_unit = op.op inside {cex_pkg::OP_MUL, cex_pkg::OP_DIV,
                        cex_pkg::OP_MFHI, cex_pkg::OP_MFLO};
    waits = 0;
    @(negedge clock_i);
    issue_o = op;
    @(posedge clock_i);
    while (hold_i || (multiply_divide_unit && stall_i)) begin
      waits++;
      @(posedge clock_i);
    end
    #1;
  endtask : send

  // released fields show their inverse, not the last value
  task automatic idle;
    @(negedge clock_i);
    issue_o = {1'b0, ~issue_o[$bits(issue_o)-2:0]};
  endtask : idle
endmodule : cex_issuer_model
